/* logic/estop_consts.svh */
`ifndef ESTOP_CONSTS_SVH
`define ESTOP_CONSTS_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ESTOP_CLK_NS         50
`define ESTOP_STEP_MS        10
`define ESTOP_STEP_CYCLES    (`ESTOP_STEP_MS * 1000000 / `ESTOP_CLK_NS)
`define ESTOP_WIN_MAX_S      30
`define ESTOP_WIN_MAX_STEPS  (`ESTOP_WIN_MAX_S * 1000 / `ESTOP_STEP_MS)
`define ESTOP_WIN_DEF_MS     30
`define ESTOP_WIN_DEF_STEPS  (`ESTOP_WIN_DEF_MS / `ESTOP_STEP_MS)

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define ESTOP_WIN_W          12
`define ESTOP_PRE_W          18
`define ESTOP_ADDR_W         8
`define ESTOP_DATA_W         32
`define ESTOP_IRQ_W          3

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ESTOP_REG_CTRL       8'h00
`define ESTOP_REG_WINDOW     8'h04
`define ESTOP_REG_STATUS     8'h08
`define ESTOP_REG_IRQ_STAT   8'h0C
`define ESTOP_REG_IRQ_MASK   8'h10

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define ESTOP_CTRL_W         5
`define ESTOP_CTRL_RESET     5'h1D
`define ESTOP_IRQ_ERR_SET    0
`define ESTOP_IRQ_PERMIT_OFF 1
`define ESTOP_IRQ_ERR_CLR    2

`endif

/* logic/estop_pkg.sv */
`default_nettype none
`include "estop_consts.svh"

package estop_pkg;

    typedef enum logic [1:0] {
        IN_SINGLE,
        IN_EQUIV,
        IN_COMPL,
        IN_RSVD
    } input_type_t;

    typedef struct packed {
        logic        mm_en;
        logic        fault_en;
        logic        run;
        input_type_t in_type;
    } ctrl_t;

    typedef struct packed {
        logic nc1;
        logic ch2;
    } contacts_t;

    typedef struct packed {
        logic                       wr;
        logic                       rd;
        logic [`ESTOP_ADDR_W-1:0]   addr;
        logic [`ESTOP_DATA_W-1:0]   wdata;
    } reg_req_t;

    typedef struct packed {
        logic permit;
        logic fault;
        logic mismatch;
    } safety_out_t;

endpackage
`default_nettype wire

/* logic/contact_sync.sv */
`timescale 1ns/10ps
`default_nettype none
`include "estop_consts.svh"

module contact_sync (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                ce,
    // Contacts
    input  wire estop_pkg::contacts_t raw,
    output var  estop_pkg::contacts_t clean
);
    import estop_pkg::*;

    contacts_t s1;
    contacts_t s2;
    contacts_t s3;
    contacts_t next_clean;

    // A level is taken only when the second and third stages agree.
    always_comb begin
        next_clean = clean;
        if (s2 == s3) begin
            next_clean = s3;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1    <= '0;
            s2    <= '0;
            s3    <= '0;
            clean <= '0;
        end else if (ce) begin
            s1    <= raw;
            s2    <= s1;
            s3    <= s2;
            clean <= next_clean;
        end
    end

endmodule
`default_nettype wire

/* logic/mismatch_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "estop_consts.svh"

module mismatch_timer #(
    parameter int unsigned STEP_CYCLES = `ESTOP_STEP_CYCLES
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    ce,
    // Control
    input  wire logic                    run,
    input  wire logic [`ESTOP_WIN_W-1:0] window,
    // Result
    output logic                         expired
);
    logic [`ESTOP_PRE_W-1:0] pre;
    logic [`ESTOP_PRE_W-1:0] next_pre;
    logic [`ESTOP_WIN_W-1:0] steps;
    logic [`ESTOP_WIN_W-1:0] next_steps;
    logic                    next_expired;

    // Any break in the run request restarts from zero, so only an
    // unbroken disagreement can reach the window.
    always_comb begin
        next_pre     = '0;
        next_steps   = '0;
        next_expired = 1'b0;
        if (run) begin
            next_steps   = steps;
            next_expired = expired;
            if (pre == `ESTOP_PRE_W'(STEP_CYCLES - 1)) begin
                if (steps != window) begin
                    next_steps = steps + `ESTOP_WIN_W'(1);
                end
                if (steps + `ESTOP_WIN_W'(1) >= window) begin
                    next_expired = 1'b1;
                end
            end else begin
                next_pre = pre + `ESTOP_PRE_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre     <= '0;
            steps   <= '0;
            expired <= 1'b0;
        end else if (ce) begin
            pre     <= next_pre;
            steps   <= next_steps;
            expired <= next_expired;
        end
    end

endmodule
`default_nettype wire

/* logic/estop_dual_channel_monitor.sv */
// Overview of operation
// RULE_01: Permit follows active input; errors force it off.
// RULE_02: Reset clears errors and all timers.
// RULE_03: Equivalent type permits only when both read ON.
// RULE_04: Complementary permits on first ON, second OFF.
// RULE_05: Window 0..30 s, 10 ms steps; zero disables.
// RULE_06: Window must exceed the controller scan time.
// RULE_07: Mismatch forces permit off, raises fault and error.
// RULE_08: Inputs inactive then active clears mismatch error.
// RULE_09: Stopped then running mode clears mismatch error.
// RULE_10: Fault and mismatch outputs are individually enabled.
// RULE_11: Pair with a manual reset block downstream.
// RULE_12: Single type: permit follows first input, no check.
// RULE_13: Disagreement longer than window raises mismatch error.
`timescale 1ns/10ps
`default_nettype none
`include "estop_consts.svh"

module estop_dual_channel_monitor #(
    parameter int unsigned STEP_CYCLES = `ESTOP_STEP_CYCLES
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    // Register port
    input  wire estop_pkg::reg_req_t       bus_req,
    output logic [`ESTOP_DATA_W-1:0]       rdata,
    // Stop switch contacts
    input  wire estop_pkg::contacts_t      contacts,
    // Safety outputs
    output var  estop_pkg::safety_out_t    safety,
    output logic                           irq
);
    import estop_pkg::*;

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    ctrl_t                    ctrl;
    ctrl_t                    next_ctrl;
    logic [`ESTOP_WIN_W-1:0]  window;
    logic [`ESTOP_WIN_W-1:0]  next_window;
    logic [`ESTOP_IRQ_W-1:0]  irq_stat;
    logic [`ESTOP_IRQ_W-1:0]  next_irq_stat;
    logic [`ESTOP_IRQ_W-1:0]  irq_mask;
    logic [`ESTOP_IRQ_W-1:0]  next_irq_mask;
    logic [`ESTOP_IRQ_W-1:0]  events;
    logic [`ESTOP_DATA_W-1:0] next_rdata;
    logic                     next_irq;
    contacts_t                sync_c;
    logic                     err;
    logic                     next_err;
    logic                     seen_off;
    logic                     next_seen_off;
    logic                     seen_stop;
    logic                     next_seen_stop;
    safety_out_t              next_safety;
    logic                     expired;
    logic                     ch_ok;
    logic                     ch_off;
    logic                     disagree;
    logic                     check_en;

    // ---------------------------------------------------------------
    // Contact decoding
    // ---------------------------------------------------------------
    function automatic logic pass_of(input input_type_t t, input contacts_t c);
        case (t)
            IN_SINGLE: pass_of = c.nc1;
            IN_COMPL:  pass_of = c.nc1 & ~c.ch2;
            default:   pass_of = c.nc1 & c.ch2;
        endcase
    endfunction

    function automatic logic safe_of(input input_type_t t, input contacts_t c);
        case (t)
            IN_SINGLE: safe_of = ~c.nc1;
            IN_COMPL:  safe_of = ~c.nc1 & c.ch2;
            default:   safe_of = ~c.nc1 & ~c.ch2;
        endcase
    endfunction

    contact_sync u_sync (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .raw   (contacts),
        .clean (sync_c)
    );

    // The reserved type code behaves as the default equivalent type.
    assign ch_ok    = pass_of(ctrl.in_type, sync_c); // RULE_03 RULE_04 RULE_12
    assign ch_off   = safe_of(ctrl.in_type, sync_c);
    assign disagree = (ctrl.in_type != IN_SINGLE) && !ch_ok && !ch_off; // RULE_12
    assign check_en = disagree && (window != '0) && !err; // RULE_05 RULE_13

    // ---------------------------------------------------------------
    // Mismatch timing
    // ---------------------------------------------------------------
    mismatch_timer #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_timer (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .run     (check_en),
        .window  (window),
        .expired (expired)
    );

    // ---------------------------------------------------------------
    // Error and permit
    // ---------------------------------------------------------------
    // Recovery needs the whole inactive-then-active walk after the error;
    // an input that was already active when the error hit cannot clear it.
    always_comb begin
        next_err       = err;
        next_seen_off  = seen_off;
        next_seen_stop = seen_stop;
        if (err) begin
            if (ch_off) begin
                next_seen_off = 1'b1;
            end
            if (!ctrl.run) begin
                next_seen_stop = 1'b1;
            end
            if ((seen_off && ch_ok) || (seen_stop && ctrl.run)) begin
                next_err       = 1'b0; // RULE_08 RULE_09
                next_seen_off  = 1'b0;
                next_seen_stop = 1'b0;
            end
        end else if (expired) begin
            next_err = 1'b1; // RULE_07 RULE_13
        end
        next_safety.permit   = ctrl.run && ch_ok && !next_err; // RULE_01 RULE_07
        next_safety.fault    = next_err && ctrl.fault_en; // RULE_07 RULE_10
        next_safety.mismatch = next_err && ctrl.mm_en; // RULE_07 RULE_10
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            err       <= 1'b0; // RULE_02
            seen_off  <= 1'b0;
            seen_stop <= 1'b0;
            safety    <= '0;
        end else if (ce) begin
            err       <= next_err;
            seen_off  <= next_seen_off;
            seen_stop <= next_seen_stop;
            safety    <= next_safety;
        end
    end

    // ---------------------------------------------------------------
    // Registers and interrupt
    // ---------------------------------------------------------------
    always_comb begin
        events = '0;
        events[`ESTOP_IRQ_ERR_SET]    = next_err && !err;
        events[`ESTOP_IRQ_PERMIT_OFF] = safety.permit && !next_safety.permit;
        events[`ESTOP_IRQ_ERR_CLR]    = err && !next_err;
        next_ctrl     = ctrl;
        next_window   = window;
        next_irq_mask = irq_mask;
        next_rdata    = '0;
        // An event in the clearing read's own cycle stays set.
        next_irq_stat = irq_stat | events;
        if (bus_req.wr) begin
            if (bus_req.addr == `ESTOP_REG_CTRL) begin
                next_ctrl = ctrl_t'(bus_req.wdata[`ESTOP_CTRL_W-1:0]);
            end else if (bus_req.addr == `ESTOP_REG_WINDOW) begin
                // Settings beyond the longest window saturate there.
                if (bus_req.wdata > `ESTOP_DATA_W'(`ESTOP_WIN_MAX_STEPS)) begin
                    next_window = `ESTOP_WIN_W'(`ESTOP_WIN_MAX_STEPS); // RULE_05
                end else begin
                    next_window = bus_req.wdata[`ESTOP_WIN_W-1:0];
                end
            end else if (bus_req.addr == `ESTOP_REG_IRQ_MASK) begin
                next_irq_mask = bus_req.wdata[`ESTOP_IRQ_W-1:0];
            end
        end
        if (bus_req.rd) begin
            if (bus_req.addr == `ESTOP_REG_CTRL) begin
                next_rdata = `ESTOP_DATA_W'(ctrl);
            end else if (bus_req.addr == `ESTOP_REG_WINDOW) begin
                next_rdata = `ESTOP_DATA_W'(window);
            end else if (bus_req.addr == `ESTOP_REG_STATUS) begin
                next_rdata = `ESTOP_DATA_W'({sync_c, err, safety});
            end else if (bus_req.addr == `ESTOP_REG_IRQ_STAT) begin
                next_rdata    = `ESTOP_DATA_W'(irq_stat);
                next_irq_stat = events;
            end else if (bus_req.addr == `ESTOP_REG_IRQ_MASK) begin
                next_rdata = `ESTOP_DATA_W'(irq_mask);
            end
        end
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl     <= ctrl_t'(`ESTOP_CTRL_RESET);
            window   <= `ESTOP_WIN_W'(`ESTOP_WIN_DEF_STEPS); // RULE_05
            irq_stat <= '0;
            irq_mask <= '0;
            rdata    <= '0;
            irq      <= 1'b0;
        end else if (ce) begin
            ctrl     <= next_ctrl;
            window   <= next_window;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            rdata    <= next_rdata;
            irq      <= next_irq;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_reset_clears;
        @(posedge clk) disable iff (1'b0) rst |=> !err && !expired && !safety.fault;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset left an error or timer"); // RULE_02

    property p_err_blocks_permit;
        ce && next_err |=> !safety.permit && err;
    endproperty
    a_err_blocks_permit: assert property (p_err_blocks_permit) else $error("permit on with error"); // RULE_01

    property p_equiv_both_on;
        ce && ctrl.in_type == IN_EQUIV && !(sync_c.nc1 && sync_c.ch2) |=> !safety.permit;
    endproperty
    a_equiv_both_on: assert property (p_equiv_both_on) else $error("equivalent permit wrong"); // RULE_03

    property p_compl_permit;
        ce && ctrl.in_type == IN_COMPL && ctrl.run && !err && sync_c.nc1 && !sync_c.ch2 |=> safety.permit;
    endproperty
    a_compl_permit: assert property (p_compl_permit) else $error("complementary permit missing"); // RULE_04

    property p_single_follows;
        ce && ctrl.in_type == IN_SINGLE && ctrl.run && !err |=> safety.permit == $past(sync_c.nc1);
    endproperty
    a_single_follows: assert property (p_single_follows) else $error("single permit wrong"); // RULE_12

    property p_zero_window;
        ce && window == '0 && !err |=> !err;
    endproperty
    a_zero_window: assert property (p_zero_window) else $error("error with check off"); // RULE_05

    property p_mismatch_flags;
        ce && expired && !err && ctrl.fault_en && ctrl.mm_en |=> err && safety.fault && safety.mismatch;
    endproperty
    a_mismatch_flags: assert property (p_mismatch_flags) else $error("mismatch not flagged"); // RULE_07

    sequence s_released;
        ce && err && ch_off;
    endsequence
    sequence s_reactivated;
        ce && ch_ok;
    endsequence
    property p_cycle_clears;
        s_released ##1 s_reactivated |=> !err;
    endproperty
    a_cycle_clears: assert property (p_cycle_clears) else $error("input cycle did not clear"); // RULE_08

    sequence s_stopped;
        ce && err && !ctrl.run;
    endsequence
    property p_mode_clears;
        s_stopped ##1 (ce && ctrl.run) |=> !err;
    endproperty
    a_mode_clears: assert property (p_mode_clears) else $error("mode cycle did not clear"); // RULE_09

    property p_optional_outputs;
        ce && !ctrl.fault_en && !ctrl.mm_en |=> !safety.fault && !safety.mismatch;
    endproperty
    a_optional_outputs: assert property (p_optional_outputs) else $error("disabled output set"); // RULE_10

    property p_err_needs_disagree;
        $rose(err) |-> $past(expired) && $past(window) != '0;
    endproperty
    a_err_needs_disagree: assert property (p_err_needs_disagree) else $error("error without timeout"); // RULE_13

    property p_err_event;
        ce && !err && next_err |=> irq_stat[`ESTOP_IRQ_ERR_SET];
    endproperty
    a_err_event: assert property (p_err_event) else $error("error event not latched"); // RULE_07

    property p_stop_blocks_permit;
        ce && !ctrl.run |=> !safety.permit;
    endproperty
    a_stop_blocks_permit: assert property (p_stop_blocks_permit) else $error("permit on in stopped mode"); // RULE_09

    property p_window_limit;
        window <= `ESTOP_WIN_W'(`ESTOP_WIN_MAX_STEPS);
    endproperty
    a_window_limit: assert property (p_window_limit) else $error("window above its limit"); // RULE_05

endmodule
`default_nettype wire

/* verification/estop_switch_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// Stop switch contacts and downstream restart latch
// ---------------------------------------------------------------
// The second contact may trail the first by a few cycles, the way
// a real pushbutton's two blocks never break at the same instant.
module estop_switch_model (
    // Clock
    input  wire logic                 clk,
    // Commands from the bench
    input  wire logic                 want_nc1,
    input  wire logic                 want_ch2,
    input  wire logic [3:0]           lag,
    input  wire logic                 restart,
    // Contact pins and permit
    output var  estop_pkg::contacts_t pins,
    input  wire logic                 permit,
    output logic                      machine_on
);
    import estop_pkg::*;
    logic [3:0] cnt;

    initial begin
        pins = '0;
        cnt = '0;
        machine_on = 1'b0;
    end

    always @(posedge clk) begin
        pins.nc1 <= want_nc1;
        if (pins.ch2 == want_ch2) begin
            cnt <= '0;
        end else if (cnt >= lag) begin
            pins.ch2 <= want_ch2;
            cnt <= '0;
        end else begin
            cnt <= cnt + 4'd1;
        end
        // A stop drops the machine, and only a manual restart brings it back.
        if (!permit) begin
            machine_on <= 1'b0;
        end else if (restart) begin
            machine_on <= 1'b1;
        end
    end
endmodule

`default_nettype wire

/* verification/tb_estop_dual_channel_monitor.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_estop_dual_channel_monitor;
    import estop_pkg::*;
    localparam int STEP = 4;
    logic        clk = 1'b0;
    logic        rst, ce, want_nc1, want_ch2, restart, irq, machine_on;
    logic [3:0]  lag;
    reg_req_t    req;
    contacts_t   pins;
    safety_out_t safety;
    logic [31:0] rdata, rv;
    logic        n, c;
    input_type_t t;
    int          fails = 0;
    int          check_count = 0;

    estop_dual_channel_monitor #(.STEP_CYCLES(STEP)) i_estop_dual_channel_monitor (
        .clk(clk), .rst(rst), .ce(ce), .bus_req(req), .rdata(rdata),
        .contacts(pins), .safety(safety), .irq(irq));
    estop_switch_model i_estop_switch_model (
        .clk(clk), .want_nc1(want_nc1), .want_ch2(want_ch2), .lag(lag),
        .restart(restart), .pins(pins), .permit(safety.permit), .machine_on(machine_on));

    always #25 clk = ~clk;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic chk_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask

    task automatic pins_to(input logic a, input logic b, input int cycles);
        want_nc1 <= a;
        want_ch2 <= b;
        repeat (cycles) @(posedge clk);
    endtask

    task automatic chk_out(input logic p, input logic f, input logic m);
        chk_bit("permit", p, safety.permit);
        chk_bit("fault", f, safety.fault);
        chk_bit("mismatch", m, safety.mismatch);
    endtask

    function automatic logic exp_permit(input input_type_t ty, input logic a, input logic b);
        case (ty)
            IN_SINGLE: return a;
            IN_COMPL:  return a & ~b;
            default:   return a & b;
        endcase
    endfunction

    // Reset is applied mid-run as well, so the reset values are checked every time.
    task automatic do_reset();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_out(1'b0, 1'b0, 1'b0);
        reg_rd(8'h00, rv);
        chk_word("ctrl", 32'h0000_001D, rv);
        reg_rd(8'h04, rv);
        chk_word("window", 32'h0000_0003, rv);
        reg_rd(8'h10, rv);
        chk_word("irq_mask", 32'h0000_0000, rv);
        reg_rd(8'h14, rv);
        chk_word("unmapped", 32'h0000_0000, rv);
        $display("test reset done");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------
    initial begin
        #(20000 * 50);
        fails++;
        $display("Error watchdog expired");
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        req = '0;
        want_nc1 = 1'b0;
        want_ch2 = 1'b0;
        lag = 4'h0;
        restart = 1'b0;
        void'($urandom(32'hef93));
        do_reset();

        // Truth tables with the check off, then random draws.
        reg_wr(8'h04, 32'h0000_0000);
        for (int k = 0; k < 32; k++) begin
            t = input_type_t'(k < 16 ? k / 4 : $urandom % 4);
            n = k < 16 ? k[1] : 1'($urandom);
            c = k < 16 ? k[0] : 1'($urandom);
            reg_wr(8'h00, 32'h0000_001C | 32'(t));
            pins_to(n, c, 12);
            chk_bit("permit", exp_permit(t, n, c), safety.permit);
            chk_bit("mismatch", 1'b0, safety.mismatch);
        end
        reg_wr(8'h04, 32'h0000_0001);
        reg_wr(8'h00, 32'h0000_001C);
        pins_to(1'b1, 1'b0, 30);
        chk_out(1'b1, 1'b0, 1'b0);
        $display("test truth_tables done");

        // Disagreement beyond the window, masked then unmasked interrupt.
        // Contacts agree before the dual type is chosen, so no stale disagreement runs the timer.
        pins_to(1'b1, 1'b1, 12);
        reg_wr(8'h00, 32'h0000_001D);
        pins_to(1'b1, 1'b1, 2);
        chk_out(1'b1, 1'b0, 1'b0);
        pins_to(1'b1, 1'b0, 20);
        chk_out(1'b0, 1'b1, 1'b1);
        chk_bit("irq", 1'b0, irq);
        reg_rd(8'h08, rv);
        chk_word("status", 32'h0000_000B, rv & 32'h0000_000F);
        reg_wr(8'h10, 32'h0000_0001);
        chk_bit("irq", 1'b1, irq);
        reg_rd(8'h0C, rv);
        chk_bit("irq_stat", 1'b1, rv[0]);
        repeat (2) @(posedge clk);
        chk_bit("irq", 1'b0, irq);
        pins_to(1'b1, 1'b1, 12);
        chk_out(1'b0, 1'b1, 1'b1);
        pins_to(1'b0, 1'b0, 12);
        pins_to(1'b1, 1'b1, 12);
        chk_out(1'b1, 1'b0, 1'b0);
        reg_rd(8'h0C, rv);
        chk_word("irq_stat", 32'h0000_0004, rv);
        $display("test mismatch_inputs done");

        // Recovery by stopping and running again.
        pins_to(1'b0, 1'b1, 20);
        pins_to(1'b1, 1'b1, 12);
        chk_out(1'b0, 1'b1, 1'b1);
        reg_wr(8'h00, 32'h0000_0019);
        repeat (4) @(posedge clk);
        chk_bit("permit", 1'b0, safety.permit);
        reg_wr(8'h00, 32'h0000_001D);
        repeat (4) @(posedge clk);
        chk_out(1'b1, 1'b0, 1'b0);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        @(posedge clk);
        chk_bit("machine_on", 1'b1, machine_on);
        $display("test mismatch_mode done");

        // Optional outputs switched off, error still blocks permit.
        reg_wr(8'h00, 32'h0000_0005);
        pins_to(1'b1, 1'b0, 20);
        chk_out(1'b0, 1'b0, 1'b0);
        chk_bit("machine_on", 1'b0, machine_on);
        reg_rd(8'h08, rv);
        chk_bit("err_internal", 1'b1, rv[3]);
        pins_to(1'b0, 1'b0, 12);
        $display("test optional_outputs done");

        // A slow second contact inside the window is not an error.
        reg_wr(8'h00, 32'h0000_001D);
        lag <= 4'h1;
        pins_to(1'b1, 1'b1, 16);
        chk_out(1'b1, 1'b0, 1'b0);
        lag <= 4'h0;
        $display("test slow_contact done");

        // Window limits and a request lost while the clock enable is low.
        reg_wr(8'h04, 32'h0000_0FA0);
        reg_rd(8'h04, rv);
        chk_word("window", 32'h0000_0BB8, rv);
        ce <= 1'b0;
        reg_wr(8'h04, 32'h0000_0007);
        ce <= 1'b1;
        reg_rd(8'h04, rv);
        chk_word("window", 32'h0000_0BB8, rv);
        $display("test window done");

        // Complementary contacts: error, then recovery through the safe state.
        reg_wr(8'h04, 32'h0000_0001);
        reg_wr(8'h00, 32'h0000_001E);
        pins_to(1'b1, 1'b1, 12);
        chk_out(1'b0, 1'b1, 1'b1);
        pins_to(1'b0, 1'b1, 12);
        pins_to(1'b1, 1'b0, 12);
        chk_out(1'b1, 1'b0, 1'b0);
        $display("test compl_mismatch done");

        // Second reset after an error clears it.
        reg_wr(8'h00, 32'h0000_001D);
        pins_to(1'b1, 1'b0, 20);
        chk_bit("mismatch", 1'b1, safety.mismatch);
        do_reset();
        end_of_test();
    end
endmodule

`default_nettype wire
